/* design/mode_select_pkg.sv */
package mode_select_pkg;
   // ----------------------------------------
   // Bus map
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_EEDATA = 4'h8;
   localparam logic [3:0] ADDR_CMD    = 4'hC;
   // ----------------------------------------
   // Modes
   // ----------------------------------------
   typedef enum logic [3:0] {
      MODE_UART      = 4'h0,
      MODE_ASYNC_FIFO= 4'h1,
      MODE_CPU_FIFO  = 4'h2,
      MODE_HD_SERIAL = 4'h3,
      MODE_FAST_SER  = 4'h4,
      MODE_SYNC_FIFO = 4'h5,
      MODE_ABB       = 4'h6,
      MODE_SBB       = 4'h7,
      MODE_MPSE      = 4'h8
   } iface_mode_e;
   // ----------------------------------------
   // Host command values
   // ----------------------------------------
   localparam logic [7:0] CMD_RESET_MODE = 8'h00;
   localparam logic [7:0] CMD_ABB        = 8'h01;
   localparam logic [7:0] CMD_MPSE       = 8'h02;
   localparam logic [7:0] CMD_SBB        = 8'h04;
   localparam logic [7:0] CMD_FS_RESET   = 8'h10;
   localparam logic [7:0] CMD_SYNC_FIFO  = 8'h40;
   // ----------------------------------------
   // EEPROM word fields
   // ----------------------------------------
   localparam int EE_MODE_LSB  = 0;
   localparam int EE_DRIVE_LSB = 4;
   localparam int EE_SLEW_BIT  = 6;
   localparam int EE_SCHM_BIT  = 7;
   localparam int EE_PD_BIT    = 8;
   localparam logic [15:0] EE_DEFAULT = 16'h0000;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ      = 40;
   localparam int FLUSH_NS     = 250;
   localparam int WAKE_MS      = 20;
   localparam int FLUSH_CYC    = (FLUSH_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_CYC     = (WAKE_MS * 1000 * CLK_MHZ);
   localparam int LOAD_CYC     = 4;
endpackage : mode_select_pkg

/* design/mode_select_flush_wake.sv */
// Functional notes
// - Flush/wake pin only acts in FIFO or bit-bang modes.
// - Falling edge of flush/wake flags pending transfer to host.
// - Flush sends buffered data at once as short packet.
// - With pull-down enabled, pin never wakes device from suspend.
// - In UART mode ring indicator is the wake source.
// - Without other configuration the mode is UART.
// - After reset, EEPROM is read and stored mode applied.
// - Host command selects async/sync bit-bang or serial engine.
// - Command 0x40 gives sync FIFO only from async FIFO.
// - Drive, slew and Schmitt settings come from EEPROM.
// - Host may reset fast serial controller; mode from EEPROM only.
// - Command 0x10 holds fast serial in reset, 0x00 releases.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mode_select_flush_wake
   import mode_select_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_CYC
)(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        flush_wake_n,
   input  wire logic        ring_indicator_n,
   input  wire logic        suspended,
   input  wire logic        buffer_has_data,
   output logic             send_immediate,
   output logic             remote_wake,
   output logic             pins_active,
   output logic [3:0]       active_mode,
   output logic             fast_serial_reset,
   output logic [1:0]       drive_strength,
   output logic             slow_slew,
   output logic             schmitt_en
);
   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic              acc_q;
   logic [15:0]       ee_word_q;
   logic              ee_valid_q;
   logic [7:0]        cmd_q;
   logic              cmd_stb_q;
   logic              flush_seen_q;
   logic              wake_seen_q;
   logic              wr_go;
   logic              rd_go;
   assign wr_go = avs_write && acc_q;
   assign rd_go = avs_read && !acc_q;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         acc_q <= 1'b0;
      end else begin
         acc_q <= (avs_read || avs_write) && !acc_q;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !acc_q);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_go) begin
         unique case (avs_address)
            ADDR_STATUS: avs_readdata <= {24'h000000, wake_seen_q, flush_seen_q, fast_serial_reset,
                                          pins_active, active_mode};
            ADDR_EEDATA: avs_readdata <= {16'h0000, ee_word_q};
            ADDR_CMD:    avs_readdata <= {24'h000000, cmd_q};
            default:     avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ee_word_q  <= EE_DEFAULT;
         ee_valid_q <= 1'b0;
      end else if (wr_go && avs_address == ADDR_EEDATA && !ee_valid_q) begin
         ee_word_q  <= avs_writedata[15:0];
         ee_valid_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cmd_q     <= CMD_RESET_MODE;
         cmd_stb_q <= 1'b0;
      end else begin
         cmd_stb_q <= wr_go && avs_address == ADDR_CMD;
         if (wr_go && avs_address == ADDR_CMD) begin
            cmd_q <= avs_writedata[7:0];
         end
      end
   end

   // ----------------------------------------
   // EEPROM load and mode latch
   // ----------------------------------------
   logic [2:0]  load_cnt_q;
   logic [3:0]  ee_mode_q;
   logic        pulldown_q;
   logic [3:0]  ee_mode;
   assign ee_mode = ee_word_q[EE_MODE_LSB +: 4];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         load_cnt_q  <= 3'h0;
         pins_active <= 1'b0;
      end else if (!pins_active && ee_valid_q) begin
         if (load_cnt_q == 3'(LOAD_CYC - 1)) begin
            pins_active <= 1'b1;
         end else begin
            load_cnt_q <= load_cnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ee_mode_q      <= MODE_UART;
         drive_strength <= 2'h0;
         slow_slew      <= 1'b0;
         schmitt_en     <= 1'b0;
         pulldown_q     <= 1'b0;
      end else if (!pins_active && ee_valid_q) begin
         ee_mode_q      <= (ee_mode <= MODE_FAST_SER) ? ee_mode : MODE_UART;
         drive_strength <= ee_word_q[EE_DRIVE_LSB +: 2];
         slow_slew      <= ee_word_q[EE_SLEW_BIT];
         schmitt_en     <= ee_word_q[EE_SCHM_BIT];
         pulldown_q     <= ee_word_q[EE_PD_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         active_mode       <= MODE_UART;
         fast_serial_reset <= 1'b0;
      end else if (!pins_active) begin
         active_mode <= ee_mode_q;
      end else if (cmd_stb_q) begin
         if (ee_mode_q == MODE_FAST_SER) begin
            if (cmd_q == CMD_FS_RESET) begin
               fast_serial_reset <= 1'b1;
            end else if (cmd_q == CMD_RESET_MODE) begin
               fast_serial_reset <= 1'b0;
            end
         end else begin
            unique case (cmd_q)
               CMD_RESET_MODE: active_mode <= ee_mode_q;
               CMD_ABB:        active_mode <= MODE_ABB;
               CMD_SBB:        active_mode <= MODE_SBB;
               CMD_MPSE:       active_mode <= MODE_MPSE;
               CMD_SYNC_FIFO: begin
                  if (ee_mode_q == MODE_ASYNC_FIFO) begin
                     active_mode <= MODE_SYNC_FIFO;
                  end
               end
               default: active_mode <= active_mode;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Flush / wake pin
   // ----------------------------------------
   logic        pin_q;
   logic        pin_allowed;
   logic [31:0] low_cnt_q;
   logic        wake_done_q;
   assign pin_allowed = pins_active && (active_mode == MODE_ASYNC_FIFO || active_mode == MODE_CPU_FIFO ||
                        active_mode == MODE_SYNC_FIFO || active_mode == MODE_ABB ||
                        active_mode == MODE_SBB);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= flush_wake_n;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         send_immediate <= 1'b0;
         flush_seen_q   <= 1'b0;
      end else begin
         send_immediate <= pin_allowed && pin_q && !flush_wake_n && !suspended;
         if (pin_allowed && pin_q && !flush_wake_n && !suspended) begin
            flush_seen_q <= 1'b1;
         end else if (rd_go && avs_address == ADDR_STATUS) begin
            flush_seen_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         low_cnt_q   <= 32'h0;
         wake_done_q <= 1'b0;
      end else if (flush_wake_n) begin
         low_cnt_q   <= 32'h0;
         wake_done_q <= 1'b0;
      end else if (low_cnt_q != 32'(WAKE_CYCLES)) begin
         low_cnt_q <= low_cnt_q + 32'h1;
      end else begin
         wake_done_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         remote_wake <= 1'b0;
         wake_seen_q <= 1'b0;
      end else begin
         if (active_mode == MODE_UART) begin
            remote_wake <= pins_active && suspended && !ring_indicator_n;
         end else begin
            remote_wake <= pin_allowed && suspended && !pulldown_q && !wake_done_q &&
                           low_cnt_q == 32'(WAKE_CYCLES);
         end
         if (remote_wake) begin
            wake_seen_q <= 1'b1;
         end else if (rd_go && avs_address == ADDR_STATUS) begin
            wake_seen_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_flush_on_edge: assert property (@(posedge core_clk) disable iff (reset)
      (pin_allowed && $fell(flush_wake_n) && !suspended) |=> send_immediate)
      else $error("flush edge not flagged");
   a_flush_gated: assert property (@(posedge core_clk) disable iff (reset)
      send_immediate |-> $past(pin_allowed))
      else $error("flush in wrong mode");
   a_flush_pulse: assert property (@(posedge core_clk) disable iff (reset)
      send_immediate |=> !send_immediate)
      else $error("flush longer than one cycle");
   a_pulldown_wake: assert property (@(posedge core_clk) disable iff (reset)
      (remote_wake && active_mode != MODE_UART) |-> !pulldown_q)
      else $error("wake with pulldown");
   a_uart_ring: assert property (@(posedge core_clk) disable iff (reset)
      (active_mode == MODE_UART && $past(active_mode) == MODE_UART && remote_wake) |-> $past(!ring_indicator_n))
      else $error("uart wake not from ring");
   a_pins_idle: assert property (@(posedge core_clk) disable iff (reset)
      !pins_active |-> (!send_immediate && !remote_wake))
      else $error("pins active before load");
   a_sync_fifo: assert property (@(posedge core_clk) disable iff (reset)
      (active_mode == MODE_SYNC_FIFO) |-> (ee_mode_q == MODE_ASYNC_FIFO))
      else $error("sync fifo without async fifo");
   a_fs_reset: assert property (@(posedge core_clk) disable iff (reset)
      (pins_active && cmd_stb_q && cmd_q == CMD_FS_RESET && ee_mode_q == MODE_FAST_SER) |=> fast_serial_reset)
      else $error("fast serial reset not held");
endmodule : mode_select_flush_wake
`default_nettype wire

/* verification/pin_driver_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Outside controller on the flush/wake pin
// ----------------------------------------
module pin_driver_model (
   input  wire logic core_clk,
   output logic      flush_wake_n,
   output logic      ring_indicator_n,
   output logic      suspended
);
   initial begin
      flush_wake_n     = 1'b1;
      ring_indicator_n = 1'b1;
      suspended        = 1'b0;
   end
   // Low pulse of n clocks, after a quiet gap
   task automatic pulse(input int n);
      repeat (4) @(posedge core_clk);
      flush_wake_n <= 1'b0;
      repeat (n) @(posedge core_clk);
      flush_wake_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask : pulse
   // Host suspend and ring line
   task automatic set_line(input logic s, input logic r);
      @(posedge core_clk);
      suspended        <= s;
      ring_indicator_n <= r;
   endtask : set_line
endmodule : pin_driver_model
`default_nettype wire

/* verification/tb_mode_select_flush_wake.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_mode_select_flush_wake
   import mode_select_pkg::*;
();
   localparam int WK = 50;
   logic        core_clk = 1'b0, reset = 1'b1;
   logic [3:0]  avs_address = 4'h0, active_mode;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic        flush_wake_n, ring_indicator_n, suspended, buffer_has_data = 1'b0;
   logic        send_immediate, remote_wake, pins_active, fast_serial_reset;
   logic [1:0]  drive_strength;
   logic        slow_slew, schmitt_en, wake_d = 1'b0;
   logic [15:0] lfsr_q = 16'h3B77, ee_q = 16'h0, seen;
   logic [31:0] rdq[$];
   logic [1:0]  evq[$];
   logic [1:0]  code;
   int          err_count = 0, checks = 0;
   always #12.5 core_clk = ~core_clk;
   mode_select_flush_wake #(.WAKE_CYCLES(WK)) i_mode_select_flush_wake (
      .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .flush_wake_n(flush_wake_n),
      .ring_indicator_n(ring_indicator_n), .suspended(suspended), .buffer_has_data(buffer_has_data),
      .send_immediate(send_immediate), .remote_wake(remote_wake), .pins_active(pins_active),
      .active_mode(active_mode), .fast_serial_reset(fast_serial_reset),
      .drive_strength(drive_strength), .slow_slew(slow_slew), .schmitt_en(schmitt_en));
   pin_driver_model i_pin_driver_model (.core_clk(core_clk), .flush_wake_n(flush_wake_n),
      .ring_indicator_n(ring_indicator_n), .suspended(suspended));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, e, s);
      end
   endtask : cmp
   always @(posedge core_clk) begin
      wake_d <= remote_wake;
      seen = {schmitt_en, slow_slew, drive_strength, active_mode, avs_readdata[7:0]};
      if (avs_read && !avs_waitrequest) begin
         if (rdq.size() == 0) cmp("read", 16'hDEAD, seen);
         else begin
            cmp("status", rdq[0][15:0] & rdq[0][31:16], seen & rdq[0][31:16]);
            void'(rdq.pop_front());
         end
      end
      code = (evq.size() != 0) ? evq[0] : 2'd0;
      if (!reset && send_immediate === 1'b1) cmp("flush", {14'h0, code}, 16'd1);
      if (!reset && remote_wake === 1'b1 && !wake_d) cmp("wake", {14'h0, code}, 16'd2);
      if (!reset && (send_immediate === 1'b1 || (remote_wake === 1'b1 && !wake_d)) && code != 0)
         void'(evq.pop_front());
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   function automatic logic [15:0] next_rand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : next_rand
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
         conclude();
      end else begin
         avs_write <= 1'b0;
         avs_read  <= 1'b0;
      end
   endtask : bus
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      rdq.push_back({m, e});
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic rstat(input logic [3:0] m, input logic fs);
      rd(ADDR_STATUS, {ee_q[7:4], m, 2'b00, fs, 1'b1, m}, 16'hFF3F);
   endtask : rstat
   task automatic cmd(input logic [7:0] v);
      bus(1'b1, ADDR_CMD, {24'h0, v});
      repeat (4) @(posedge core_clk);
   endtask : cmd
   task automatic load(input logic [3:0] m, input logic pd);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      lfsr_q = next_rand(lfsr_q);
      ee_q = {7'h0, pd, lfsr_q[3:0], m};
      buffer_has_data <= lfsr_q[5];
      bus(1'b1, ADDR_EEDATA, {16'h0, ee_q});
      repeat (8) @(posedge core_clk);
   endtask : load
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      rd(ADDR_STATUS, 16'h0000, 16'hFFFF);
      rd(4'h2, 16'h0000, 16'h00FF);
      load(MODE_UART, 1'b0);
      rstat(MODE_UART, 1'b0);
      cmd(CMD_SYNC_FIFO);
      rstat(MODE_UART, 1'b0);
      i_pin_driver_model.pulse(FLUSH_CYC);
      i_pin_driver_model.set_line(1'b1, 1'b1);
      i_pin_driver_model.pulse(WK + 10);
      evq.push_back(2'd2);
      i_pin_driver_model.set_line(1'b1, 1'b0);
      repeat (4) @(posedge core_clk);
      i_pin_driver_model.set_line(1'b0, 1'b1);
      load(MODE_ASYNC_FIFO, 1'b0);
      rstat(MODE_ASYNC_FIFO, 1'b0);
      evq.push_back(2'd1);
      i_pin_driver_model.pulse(FLUSH_CYC);
      rd(ADDR_STATUS, 16'h0040, 16'h0040);
      rd(ADDR_STATUS, 16'h0000, 16'h0040);
      i_pin_driver_model.set_line(1'b1, 1'b1);
      evq.push_back(2'd2);
      i_pin_driver_model.pulse(WK + 10);
      i_pin_driver_model.set_line(1'b0, 1'b1);
      cmd(CMD_FS_RESET);
      rstat(MODE_ASYNC_FIFO, 1'b0);
      cmd(CMD_SYNC_FIFO);
      rstat(MODE_SYNC_FIFO, 1'b0);
      for (int i = 0; i < 3; i++) begin
         cmd(i == 0 ? CMD_ABB : i == 1 ? CMD_SBB : CMD_MPSE);
         rstat(i == 0 ? MODE_ABB : i == 1 ? MODE_SBB : MODE_MPSE, 1'b0);
         if (i < 2) evq.push_back(2'd1);
         i_pin_driver_model.pulse(FLUSH_CYC);
      end
      cmd(CMD_RESET_MODE);
      rstat(MODE_ASYNC_FIFO, 1'b0);
      load(MODE_ASYNC_FIFO, 1'b1);
      i_pin_driver_model.set_line(1'b1, 1'b1);
      i_pin_driver_model.pulse(WK + 10);
      i_pin_driver_model.set_line(1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         load(i == 0 ? MODE_CPU_FIFO : i == 1 ? MODE_HD_SERIAL : 4'h9, 1'b0);
         rstat(i == 0 ? MODE_CPU_FIFO : i == 1 ? MODE_HD_SERIAL : MODE_UART, 1'b0);
         if (i == 0) evq.push_back(2'd1);
         i_pin_driver_model.pulse(FLUSH_CYC);
      end
      load(MODE_FAST_SER, 1'b0);
      cmd(CMD_FS_RESET);
      rstat(MODE_FAST_SER, 1'b1);
      cmd(CMD_SBB);
      rstat(MODE_FAST_SER, 1'b1);
      i_pin_driver_model.pulse(FLUSH_CYC);
      cmd(CMD_RESET_MODE);
      rstat(MODE_FAST_SER, 1'b0);
      repeat (10) @(posedge core_clk);
      cmp("pending", 16'h0, 16'(rdq.size() + evq.size()));
      conclude();
   end
endmodule : tb_mode_select_flush_wake
`default_nettype wire
